// >>> inc/hpm_pkg.sv
package hpm_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RST_MIN_NS = 560;
  localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_US = 60300;
  localparam int INIT_CYC_DEF = INIT_US * CLK_MHZ;
  localparam logic [3:0] SEL_SPI = 4'h0;
  localparam logic [3:0] SEL_PAR_MASK = 4'hE;
  localparam logic [3:0] SEL_PAR_VAL = 4'h4;
  localparam int ACT_DIV = 5000000;
  localparam int SPI_HALF = 6;
  // Controller register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX = 8'h04;
  localparam logic [7:0] OFS_RX = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_ISR = 8'h10;
  localparam logic [7:0] OFS_IMR = 8'h14;
  localparam logic [7:0] OFS_ADDR = 8'h18;
  localparam int ST_DONE = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_INIT = 2;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_PAR = 2;
  localparam int CTRL_RST = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// >>> inc/hpm_if.sv
`timescale 1ns/1ps
interface hpm_if;
  logic [3:0] iface_select;
  logic chip_sel_n;
  logic spi_clk;
  logic mosi_par_addr_bit0;
  logic miso_o;
  logic miso_oe_n;
  logic par_addr_bit1_h;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [7:0] par_data_bus_h;
  logic par_data_bus_h_oe_n;
  logic [7:0] par_data_bus_d;
  logic par_data_bus_d_oe_n;
  logic irq_out_n;
  logic hw_reset_n;
  logic link_led_n;
  logic speed_led_n;
  logic duplex_led_n;
  logic activity_led_n;
  logic collision_led_n;
  logic miso_pin;
  logic [7:0] data_pin;
  // Device wins, then host; data bus else pull-up
  always_comb begin
    miso_pin = !miso_oe_n ? miso_o : par_addr_bit1_h;
    if (!par_data_bus_d_oe_n) begin
      data_pin = par_data_bus_d;
    end else if (!par_data_bus_h_oe_n) begin
      data_pin = par_data_bus_h;
    end else begin
      data_pin = 8'hFF;
    end
  end
  modport dev (input iface_select, chip_sel_n, spi_clk, mosi_par_addr_bit0,
    miso_pin, read_strobe_n, write_strobe_n, data_pin, hw_reset_n,
    output miso_o, miso_oe_n, par_data_bus_d, par_data_bus_d_oe_n,
    irq_out_n, link_led_n, speed_led_n, duplex_led_n, activity_led_n,
    collision_led_n);
  modport host (output iface_select, chip_sel_n, spi_clk,
    mosi_par_addr_bit0, par_addr_bit1_h, read_strobe_n, write_strobe_n,
    par_data_bus_h, par_data_bus_h_oe_n, hw_reset_n,
    input miso_pin, data_pin, irq_out_n, link_led_n, speed_led_n,
    duplex_led_n, activity_led_n, collision_led_n);
endinterface

// >>> rtl/hpm_dev.sv
`timescale 1ns/1ps
// Contract
// [R1] Select 0000 SPI, 010X parallel
// [R2] Link, speed, duplex indicators active low
// [R3] Activity low idle, toggles on traffic
// [R4] Collision indicator low during collision
// [R5] SPI clock used only in SPI
// [R6] MOSI pin doubles as address bit 0
// [R7] MISO pin doubles as address bit 1
// [R8] Read strobe reads in parallel mode
// [R9] Write strobe writes in parallel mode
// [R10] Eight-bit data bus both ways, parallel
// [R11] Interrupt output low while event pending
// [R12] Host holds reset low over 560ns
// [R13] Device initialises 60.3ms after reset
// [R14] Internal clock from 25MHz source
// [R15] Chip select active low gates activity
// [R16] Interrupt needs enable, unmasked event, spacing
module hpm_dev #(
  parameter int INIT_CYC = hpm_pkg::INIT_CYC_DEF
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  hpm_if.dev pins,
  input wire logic link_up_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic traffic_in,
  input wire logic collision_in,
  input wire logic irq_pin_enable_in,
  input wire logic [7:0] irq_event_in,
  input wire logic [7:0] irq_mask_in,
  input wire logic [15:0] irq_pending_time_in,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic [1:0] reg_addr_out,
  output logic init_done_out
);
  // clk_sys_in is the 100MHz internal clock [R14]
  localparam int SYN = 12;
  logic [SYN-1:0] s1_reg;
  logic [SYN-1:0] s2_reg;
  logic [SYN-1:0] raw;
  logic [3:0] sel;
  logic cs_n, sck, mosi, a1, rd_n, wr_n, rst_n;
  logic is_spi, is_par;
  assign raw = {pins.iface_select, pins.chip_sel_n, pins.spi_clk,
    pins.mosi_par_addr_bit0, pins.miso_pin, pins.read_strobe_n,
    pins.write_strobe_n, pins.hw_reset_n, 1'b0};
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_reg <= '1;
      s2_reg <= '1;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  assign {sel, cs_n, sck, mosi, a1, rd_n, wr_n, rst_n} = s2_reg[SYN-1:1];
  assign is_spi = (sel == hpm_pkg::SEL_SPI); // [R1]
  assign is_par = ((sel & hpm_pkg::SEL_PAR_MASK) == hpm_pkg::SEL_PAR_VAL); // [R1]

  // Init timer restarts while reset pin is low [R13]
  logic [31:0] init_cnt_reg;
  logic rdy;
  assign rdy = (init_cnt_reg == 32'h0);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      init_cnt_reg <= 32'(INIT_CYC);
    end else if (!rst_n) begin
      init_cnt_reg <= 32'(INIT_CYC); // [R13]
    end else if (!rdy) begin
      init_cnt_reg <= init_cnt_reg - 32'h1;
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) init_done_out <= 1'b0;
    else init_done_out <= rdy && rst_n;
  end

  logic act;
  assign act = rdy && rst_n && !cs_n; // [R15]

  // Minimal SPI byte-pair: address byte then data byte, mode 0
  logic sck_d_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] rd_data_reg;
  logic [1:0] addr_reg;
  logic phase_reg;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) sck_d_reg <= 1'b0;
    else sck_d_reg <= sck;
  end
  logic sck_rise, sck_fall;
  assign sck_rise = is_spi && sck && !sck_d_reg; // [R5]
  assign sck_fall = is_spi && !sck && sck_d_reg; // [R5]

  logic spi_done;
  assign spi_done = act && sck_rise && bit_reg == 4'h7;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      phase_reg <= 1'b0;
      addr_reg <= 2'h0;
    end else if (!act || !is_spi) begin
      bit_reg <= 4'h0;
      phase_reg <= 1'b0;
      sh_reg <= rd_data_reg;
    end else if (sck_rise) begin
      sh_reg <= {sh_reg[6:0], mosi}; // [R6]
      bit_reg <= (bit_reg == 4'h7) ? 4'h0 : bit_reg + 4'h1;
      if (bit_reg == 4'h7 && !phase_reg) begin
        addr_reg <= {sh_reg[0], mosi};
        phase_reg <= 1'b1;
        // Second byte returns read data, not the address echo
        sh_reg <= rd_data_reg; // [R7]
      end
    end
  end

  // Register writes, both modes
  logic par_wr_d_reg;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      par_wr_d_reg <= 1'b1;
      reg_wr_out <= 1'b0;
      reg_wdata_out <= 8'h00;
      reg_addr_out <= 2'h0;
    end else begin
      par_wr_d_reg <= wr_n;
      reg_wr_out <= 1'b0;
      if (act && is_par && !wr_n && par_wr_d_reg) begin
        reg_wr_out <= 1'b1; // [R9]
        reg_wdata_out <= pins.data_pin; // [R10]
        reg_addr_out <= {a1, mosi}; // [R6] [R7]
      end else if (spi_done && phase_reg) begin
        reg_wr_out <= 1'b1;
        reg_wdata_out <= {sh_reg[6:0], mosi};
        reg_addr_out <= addr_reg;
      end
    end
  end
  // Read-back holds the last written byte
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) rd_data_reg <= 8'h00;
    else if (reg_wr_out) rd_data_reg <= reg_wdata_out;
  end

  // Pin drivers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pins.miso_o <= 1'b0;
      pins.miso_oe_n <= 1'b1;
      pins.par_data_bus_d <= 8'h00;
      pins.par_data_bus_d_oe_n <= 1'b1;
    end else begin
      pins.miso_oe_n <= !(act && is_spi); // [R7]
      if (sck_fall || !act) pins.miso_o <= sh_reg[7]; // [R7]
      pins.par_data_bus_d_oe_n <= !(act && is_par && !rd_n); // [R8] [R10]
      pins.par_data_bus_d <= rd_data_reg; // [R10]
    end
  end

  // Indicators
  logic [22:0] act_cnt_reg;
  logic act_tgl_reg;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      act_cnt_reg <= 23'h0;
      act_tgl_reg <= 1'b0;
    end else if (!traffic_in) begin
      act_cnt_reg <= 23'h0;
      act_tgl_reg <= 1'b0;
    end else if (act_cnt_reg == 23'(hpm_pkg::ACT_DIV - 1)) begin
      act_cnt_reg <= 23'h0;
      act_tgl_reg <= !act_tgl_reg; // [R3]
    end else begin
      act_cnt_reg <= act_cnt_reg + 23'h1;
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pins.link_led_n <= 1'b1;
      pins.speed_led_n <= 1'b1;
      pins.duplex_led_n <= 1'b1;
      pins.activity_led_n <= 1'b1;
      pins.collision_led_n <= 1'b1;
    end else begin
      pins.link_led_n <= !link_up_in; // [R2]
      pins.speed_led_n <= !speed_100_in; // [R2]
      pins.duplex_led_n <= !full_duplex_in; // [R2]
      pins.activity_led_n <= !link_up_in || act_tgl_reg; // [R3]
      pins.collision_led_n <= !collision_in; // [R4]
    end
  end

  // Interrupt with spacing between assertions
  logic [7:0] pend_reg;
  logic [15:0] gap_reg;
  logic any;
  assign any = |(pend_reg & irq_mask_in);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) pend_reg <= 8'h00;
    else pend_reg <= irq_event_in; // [R11]
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gap_reg <= 16'h0;
      pins.irq_out_n <= 1'b1;
    end else if (!(irq_pin_enable_in && any && rdy)) begin
      if (!pins.irq_out_n) gap_reg <= irq_pending_time_in; // [R16]
      else if (gap_reg != 16'h0) gap_reg <= gap_reg - 16'h1;
      pins.irq_out_n <= 1'b1; // [R11]
    end else if (gap_reg == 16'h0) begin
      pins.irq_out_n <= 1'b0; // [R11] [R16]
    end else begin
      gap_reg <= gap_reg - 16'h1;
    end
  end
endmodule

// >>> rtl/hpm_host.sv
`timescale 1ns/1ps
module hpm_host (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  hpm_if.host pins,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq_out
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_RST = 2'b01, HS_XFER = 2'b10, HS_END = 2'b11
  } hpm_st_t;
  hpm_st_t st_reg;
  logic [1:0] s1_reg, s2_reg;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_reg <= 2'b11;
      s2_reg <= 2'b11;
    end else begin
      s1_reg <= {pins.irq_out_n, pins.miso_pin};
      s2_reg <= s1_reg;
    end
  end
  logic [7:0] ctrl_reg, tx_reg, rx_reg, mask_reg;
  logic [1:0] addr_reg;
  logic [2:0] isr_reg;
  logic [7:0] data_in_sync1, data_in_sync2;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_in_sync1 <= 8'h00;
      data_in_sync2 <= 8'h00;
    end else begin
      data_in_sync1 <= pins.data_pin;
      data_in_sync2 <= data_in_sync1;
    end
  end
  logic [15:0] cnt_reg;
  logic [4:0] bit_reg;
  logic [15:0] sh_reg;
  logic done_ev, irq_ev, init_ev;
  logic aw_h, w_h;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic wr_go;
  assign wr_go = aw_h && w_h && !bvalid;
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      hpm_pkg::OFS_CTRL: rd_mux = {24'h0, ctrl_reg};
      hpm_pkg::OFS_TX: rd_mux = {24'h0, tx_reg};
      hpm_pkg::OFS_RX: rd_mux = {24'h0, rx_reg};
      hpm_pkg::OFS_STAT: rd_mux = {31'h0, st_reg != HS_IDLE};
      hpm_pkg::OFS_ISR: rd_mux = {29'h0, isr_reg};
      hpm_pkg::OFS_IMR: rd_mux = {24'h0, mask_reg};
      hpm_pkg::OFS_ADDR: rd_mux = {30'h0, addr_reg};
      default: rd_mux = 32'h0;
    endcase
  endfunction
  function automatic logic known(input logic [7:0] a);
    known = (a <= hpm_pkg::OFS_ADDR) && (a[1:0] == 2'h0);
  endfunction
  // AXI4-Lite write side
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_h <= 1'b0; w_h <= 1'b0; aw_a <= 8'h00; w_d <= 32'h0;
      awready <= 1'b1; wready <= 1'b1; bvalid <= 1'b0; bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_h <= 1'b1; aw_a <= awaddr; awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_h <= 1'b1; w_d <= wdata; wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= known(aw_a) ? hpm_pkg::RESP_OK : hpm_pkg::RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0; aw_h <= 1'b0; w_h <= 1'b0;
        awready <= 1'b1; wready <= 1'b1;
      end
    end
  end
  // Read answers one cycle after address
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      arready <= 1'b1; rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0; rvalid <= 1'b1;
      rdata <= rd_mux(araddr);
      rresp <= known(araddr) ? hpm_pkg::RESP_OK : hpm_pkg::RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0; arready <= 1'b1;
    end
  end
  logic wsel;
  assign wsel = wr_go && wstrb[0];
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= 8'h00; tx_reg <= 8'h00; mask_reg <= 8'h00; addr_reg <= 2'h0;
    end else begin
      if (st_reg == HS_END) ctrl_reg[hpm_pkg::CTRL_GO] <= 1'b0;
      if (st_reg == HS_RST && cnt_reg == 16'h0)
        ctrl_reg[hpm_pkg::CTRL_RST] <= 1'b0;
      if (wsel) begin
        case (aw_a)
          hpm_pkg::OFS_CTRL: ctrl_reg <= w_d[7:0];
          hpm_pkg::OFS_TX: tx_reg <= w_d[7:0];
          hpm_pkg::OFS_IMR: mask_reg <= w_d[7:0];
          hpm_pkg::OFS_ADDR: addr_reg <= w_d[1:0];
          default: ;
        endcase
      end
    end
  end
  // W1C status; a new event beats the clear
  logic [2:0] ev;
  logic irq_d_reg;
  assign ev = {init_ev, irq_ev, done_ev};
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      isr_reg <= 3'h0; irq_d_reg <= 1'b1; irq_out <= 1'b0;
    end else begin
      irq_d_reg <= s2_reg[1];
      isr_reg <= (isr_reg & ~((wsel && aw_a == hpm_pkg::OFS_ISR) ?
        w_d[2:0] : 3'h0)) | ev;
      irq_out <= |(isr_reg & mask_reg[2:0]);
    end
  end
  assign irq_ev = irq_d_reg && !s2_reg[1];
  assign init_ev = 1'b0;
  // Pin sequencer
  logic par;
  assign par = ctrl_reg[hpm_pkg::CTRL_PAR];
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= HS_IDLE; cnt_reg <= 16'h0; bit_reg <= 5'h0; sh_reg <= 16'h0;
      rx_reg <= 8'h00; done_ev <= 1'b0;
      pins.iface_select <= hpm_pkg::SEL_SPI; pins.chip_sel_n <= 1'b1;
      pins.spi_clk <= 1'b0; pins.mosi_par_addr_bit0 <= 1'b0;
      pins.par_addr_bit1_h <= 1'b0; pins.read_strobe_n <= 1'b1;
      pins.write_strobe_n <= 1'b1; pins.par_data_bus_h <= 8'h00;
      pins.par_data_bus_h_oe_n <= 1'b1; pins.hw_reset_n <= 1'b1;
    end else begin
      done_ev <= 1'b0;
      pins.iface_select <= par ? hpm_pkg::SEL_PAR_VAL : hpm_pkg::SEL_SPI;
      unique case (st_reg)
        HS_IDLE: begin
          if (ctrl_reg[hpm_pkg::CTRL_RST]) begin
            pins.hw_reset_n <= 1'b0; // [R12]
            cnt_reg <= 16'(hpm_pkg::RST_MIN_CYC + 1);
            st_reg <= HS_RST;
          end else if (ctrl_reg[hpm_pkg::CTRL_GO]) begin
            pins.chip_sel_n <= 1'b0; // [R15]
            cnt_reg <= 16'(hpm_pkg::SPI_HALF);
            bit_reg <= 5'h0;
            sh_reg <= {6'h0, addr_reg, tx_reg};
            st_reg <= HS_XFER;
            if (par) begin
              pins.mosi_par_addr_bit0 <= addr_reg[0];
              pins.par_addr_bit1_h <= addr_reg[1];
              pins.par_data_bus_h <= tx_reg;
              pins.par_data_bus_h_oe_n <= !ctrl_reg[hpm_pkg::CTRL_WR];
              pins.write_strobe_n <= !ctrl_reg[hpm_pkg::CTRL_WR];
              pins.read_strobe_n <= ctrl_reg[hpm_pkg::CTRL_WR]; // [R8]
            end else begin
              pins.read_strobe_n <= 1'b1; // [R8]
            end
          end
        end
        HS_RST: begin
          if (cnt_reg == 16'h0) begin
            pins.hw_reset_n <= 1'b1;
            st_reg <= HS_IDLE;
          end else cnt_reg <= cnt_reg - 16'h1;
        end
        HS_XFER: begin
          if (cnt_reg != 16'h0) cnt_reg <= cnt_reg - 16'h1;
          else if (par) begin
            rx_reg <= data_in_sync2; // [R10]
            st_reg <= HS_END;
          end else begin
            cnt_reg <= 16'(hpm_pkg::SPI_HALF);
            if (!pins.spi_clk) begin
              pins.mosi_par_addr_bit0 <= sh_reg[15];
              pins.spi_clk <= 1'b1; // [R5]
            end else begin
              pins.spi_clk <= 1'b0;
              sh_reg <= {sh_reg[14:0], s2_reg[0]};
              bit_reg <= bit_reg + 5'h1;
              if (bit_reg == 5'hF) st_reg <= HS_END;
            end
          end
        end
        HS_END: begin
          if (!par) rx_reg <= sh_reg[7:0];
          pins.chip_sel_n <= 1'b1;
          pins.read_strobe_n <= 1'b1;
          pins.write_strobe_n <= 1'b1;
          pins.par_data_bus_h_oe_n <= 1'b1;
          done_ev <= 1'b1;
          st_reg <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> verif/hpm_asserts.sv
`timescale 1ns/1ps
module hpm_asserts #(
  parameter int INIT_CYC = 50
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] iface_select,
  input wire logic chip_sel_n,
  input wire logic spi_clk,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic miso_oe_n,
  input wire logic par_data_bus_d_oe_n,
  input wire logic hw_reset_n,
  input wire logic link_up_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic traffic_in,
  input wire logic collision_in,
  input wire logic link_led_n,
  input wire logic speed_led_n,
  input wire logic duplex_led_n,
  input wire logic activity_led_n,
  input wire logic collision_led_n,
  input wire logic irq_pin_enable_in,
  input wire logic irq_out_n,
  input wire logic reg_wr_out,
  input wire logic init_done_out
);
  int hi_cnt;
  logic [6:0] low_cnt;
  logic par_mode;
  assign par_mode = (iface_select & hpm_pkg::SEL_PAR_MASK) ==
    hpm_pkg::SEL_PAR_VAL;
  // Saturating, so a long reset pulse never wraps into a short count
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_cnt <= '0;
    end else if (hw_reset_n) begin
      low_cnt <= '0;
    end else if (low_cnt != 7'h7F) begin
      low_cnt <= low_cnt + 7'h01;
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hi_cnt <= 0;
    end else if (!hw_reset_n) begin
      hi_cnt <= 0;
    end else if (hi_cnt < INIT_CYC) begin
      hi_cnt <= hi_cnt + 1;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  property led_tracks(cause, led_n);
    ((cause)[*4] |-> !led_n) and ((!cause)[*4] |-> led_n);
  endproperty
  sequence par_write_fall;
    $fell(write_strobe_n) && !chip_sel_n && par_mode && init_done_out;
  endsequence
  a_link_led_level: assert property (
    led_tracks(link_up_in, link_led_n)) else $error("link led");
  a_speed_led_level: assert property (
    led_tracks(speed_100_in, speed_led_n)) else $error("speed led");
  a_duplex_led_level: assert property (
    led_tracks(full_duplex_in, duplex_led_n)) else $error("duplex led");
  a_coll_led_level: assert property (
    led_tracks(collision_in, collision_led_n)) else $error("collision led");
  a_act_link_down: assert property (
    (!link_up_in)[*4] |-> activity_led_n) else $error("act led on");
  a_act_idle_low: assert property (
    (link_up_in && !traffic_in)[*4] |-> !activity_led_n)
    else $error("act idle");
  a_irq_needs_enable: assert property (
    (!irq_pin_enable_in)[*4] |-> irq_out_n) else $error("irq disabled");
  a_miso_spi_only: assert property (
    !miso_oe_n |-> iface_select == hpm_pkg::SEL_SPI) else $error("miso drive");
  a_data_par_only: assert property (
    !par_data_bus_d_oe_n |-> par_mode) else $error("data drive");
  a_sclk_par_low: assert property (
    par_mode |-> !spi_clk) else $error("sclk in par");
  a_rd_spi_high: assert property (
    iface_select == hpm_pkg::SEL_SPI |-> read_strobe_n)
    else $error("rd in spi");
  a_strobe_needs_cs: assert property (
    !write_strobe_n |-> !chip_sel_n) else $error("wr without cs");
  a_wr_strobe_pulse: assert property (
    par_write_fall |-> ##[1:6] reg_wr_out) else $error("par write lost");
  a_rst_pulse_width: assert property (
    $rose(hw_reset_n) |-> low_cnt > 7'(hpm_pkg::RST_MIN_CYC))
    else $error("short reset");
  a_init_wait: assert property (
    $rose(init_done_out) |-> hi_cnt >= INIT_CYC) else $error("early ready");
  a_init_drop: assert property (
    $fell(hw_reset_n) |-> ##[1:4] !init_done_out) else $error("ready in reset");
endmodule

// >>> verif/test_host_pin_mode_and_status_outputs.sv
`timescale 1ns/1ps
module test_host_pin_mode_and_status_outputs;
  localparam int INIT_N = 50;
  logic clk_sys_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq_out;
  logic [7:0] awaddr, araddr, irq_event, irq_mask, reg_wdata, wr_data;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, reg_addr, wr_addr;
  logic [15:0] irq_time;
  logic link_up, speed_100, full_duplex, traffic, collision, irq_en;
  logic reg_wr, init_done;
  logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
  int wr_cnt = 0;
  int checks = 0;
  int bad_count = 0;
  hpm_if u_hpm_if();
  hpm_dev #(.INIT_CYC(INIT_N)) u_hpm_dev (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .pins(u_hpm_if), .link_up_in(link_up),
    .speed_100_in(speed_100), .full_duplex_in(full_duplex),
    .traffic_in(traffic), .collision_in(collision),
    .irq_pin_enable_in(irq_en), .irq_event_in(irq_event),
    .irq_mask_in(irq_mask), .irq_pending_time_in(irq_time),
    .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
    .reg_addr_out(reg_addr), .init_done_out(init_done));
  hpm_host u_hpm_host (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .pins(u_hpm_if), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .irq_out(irq_out));
  hpm_asserts #(.INIT_CYC(INIT_N)) u_hpm_asserts (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .iface_select(u_hpm_if.iface_select),
    .chip_sel_n(u_hpm_if.chip_sel_n), .spi_clk(u_hpm_if.spi_clk),
    .read_strobe_n(u_hpm_if.read_strobe_n),
    .write_strobe_n(u_hpm_if.write_strobe_n),
    .miso_oe_n(u_hpm_if.miso_oe_n),
    .par_data_bus_d_oe_n(u_hpm_if.par_data_bus_d_oe_n),
    .hw_reset_n(u_hpm_if.hw_reset_n), .link_up_in(link_up),
    .speed_100_in(speed_100), .full_duplex_in(full_duplex),
    .traffic_in(traffic), .collision_in(collision),
    .link_led_n(u_hpm_if.link_led_n), .speed_led_n(u_hpm_if.speed_led_n),
    .duplex_led_n(u_hpm_if.duplex_led_n),
    .activity_led_n(u_hpm_if.activity_led_n),
    .collision_led_n(u_hpm_if.collision_led_n),
    .irq_pin_enable_in(irq_en), .irq_out_n(u_hpm_if.irq_out_n),
    .reg_wr_out(reg_wr), .init_done_out(init_done));
  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (reg_wr === 1'h1) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word(32'(got), 32'(exp));
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk_sys_in);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk_word(32'(bresp), 32'(er));
    bready <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk_sys_in);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    axi_rd(a, d);
    chk_word(32'(rresp), 32'(er));
    chk_word(d & m, exp);
  endtask
  // Polls busy; frame length is the host's
  task automatic go(input logic [31:0] ctl);
    logic [31:0] s;
    axi_wr(hpm_pkg::OFS_CTRL, ctl, hpm_pkg::RESP_OK);
    s = 32'h1;
    while (s[0] !== 1'h0) axi_rd(hpm_pkg::OFS_STAT, s);
  endtask
  task automatic xfer(input logic [1:0] ad, input logic [7:0] d,
      input logic par);
    int c0;
    c0 = wr_cnt;
    axi_wr(hpm_pkg::OFS_ADDR, {30'h0, ad}, hpm_pkg::RESP_OK);
    axi_wr(hpm_pkg::OFS_TX, {24'h0, d}, hpm_pkg::RESP_OK);
    go({29'h0, par, 2'h3});
    chk_word(32'(wr_cnt - c0), 32'h1);
    chk_word({22'h0, wr_addr, wr_data}, {22'h0, ad, d});
    chk_bit(irq_out, 1'h1);
    axi_wr(hpm_pkg::OFS_ISR, 32'h3, hpm_pkg::RESP_OK);
    repeat (2) @(posedge clk_sys_in);
    chk_bit(irq_out, 1'h0);
    go({29'h0, par, 2'h1});
    rd_chk(hpm_pkg::OFS_RX, 32'hFF, {24'h0, d}, hpm_pkg::RESP_OK);
    axi_wr(hpm_pkg::OFS_ISR, 32'h3, hpm_pkg::RESP_OK);
  endtask
  task automatic wrap_up;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  initial begin
    int n;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = {48'h0, 4'hF};
    {link_up, speed_100, full_duplex, traffic, collision, irq_en} = '0;
    {irq_event, irq_mask, irq_time} = '0;
    sys_rst_in = 1'h1;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'h0;
    while (init_done !== 1'h1) @(posedge clk_sys_in);
    axi_wr(hpm_pkg::OFS_IMR, 32'h1, hpm_pkg::RESP_OK);
    for (int i = 0; i < 4; i++) begin
      xfer(i[1:0], pat[i], i[1]);
    end
    axi_wr(8'h40, 32'hFFFFFFFF, hpm_pkg::RESP_ERR);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, hpm_pkg::RESP_ERR);
    axi_wr(hpm_pkg::OFS_IMR, 32'h0, hpm_pkg::RESP_OK);
    go(32'h3);
    chk_bit(irq_out, 1'h0);
    rd_chk(hpm_pkg::OFS_ISR, 32'h1, 32'h1, hpm_pkg::RESP_OK);
    axi_wr(hpm_pkg::OFS_ISR, 32'h3, hpm_pkg::RESP_OK);
    irq_mask <= 8'hFF;
    irq_event <= 8'h01;
    repeat (12) @(posedge clk_sys_in);
    chk_bit(u_hpm_if.irq_out_n, 1'h1);
    irq_en <= 1'h1;
    repeat (12) @(posedge clk_sys_in);
    chk_bit(u_hpm_if.irq_out_n, 1'h0);
    rd_chk(hpm_pkg::OFS_ISR, 32'h2, 32'h2, hpm_pkg::RESP_OK);
    irq_event <= 8'h00;
    repeat (12) @(posedge clk_sys_in);
    chk_bit(u_hpm_if.irq_out_n, 1'h1);
    for (int k = 0; k < 4; k++) begin
      link_up <= k[0];
      speed_100 <= k[1];
      full_duplex <= ~k[0];
      collision <= k[0] ^ k[1];
      repeat (6) @(posedge clk_sys_in);
      chk_word({27'h0, u_hpm_if.link_led_n, u_hpm_if.speed_led_n,
        u_hpm_if.duplex_led_n, u_hpm_if.collision_led_n,
        u_hpm_if.activity_led_n},
        {27'h0, ~k[0], ~k[1], k[0], ~(k[0] ^ k[1]), ~k[0]});
    end
    axi_wr(hpm_pkg::OFS_CTRL, 32'h8, hpm_pkg::RESP_OK);
    repeat (8) @(posedge clk_sys_in);
    chk_bit(init_done, 1'h0);
    while (u_hpm_if.hw_reset_n !== 1'h1) @(posedge clk_sys_in);
    n = 0;
    while (init_done !== 1'h1) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk_bit(n >= INIT_N, 1'h1);
    axi_wr(hpm_pkg::OFS_IMR, 32'h1, hpm_pkg::RESP_OK);
    xfer(2'h3, 8'h81, 1'h0);
    wrap_up();
  end
endmodule
